// file: hdl/iopdm_params.svh
// constants for the pin drive mode port: offsets, fields, reset values
//
// Function
// R1 - each pin has own 3-bit drive mode
// R2 - output from data bit or bypass signal
// R3 - mode 000 default, driver and input off; pad in_en is still set when the pin's enabled aux line is low
// R4 - mode 001 high-z, input buffer enabled
// R5 - 010/011/111 resistive modes, 5K series
// R6 - 100/101 open drain, 110 strong both
// R7 - per pin rising, falling or both edges
// R8 - no native level-sensitive pin interrupts
// R9 - one dedicated interrupt line per port
// R10 - separate pin read and output registers
// R11 - port view and pin view registers
// R12 - per pin slow slew option
// R13 - edge event sets status, raises request
// R14 - up to 16 auxiliary output enables
`ifndef IOPDM_PARAMS_SVH
`define IOPDM_PARAMS_SVH

// port-form register byte offsets
`define IOPDM_OFF_OUT      8'h00
`define IOPDM_OFF_PINLVL   8'h04
`define IOPDM_OFF_DMB0     8'h08
`define IOPDM_OFF_DMB1     8'h0C
`define IOPDM_OFF_DMB2     8'h10
`define IOPDM_OFF_SLEW     8'h14
`define IOPDM_OFF_BYPASS   8'h18
`define IOPDM_OFF_IRQRISE  8'h1C
`define IOPDM_OFF_IRQFALL  8'h20
`define IOPDM_OFF_IRQSTAT  8'h24
`define IOPDM_OFF_IRQMASK  8'h28
`define IOPDM_OFF_AUXEN    8'h2C
`define IOPDM_OFF_AUXSEL   8'h30
// pin-form registers: base + 4 * pin
`define IOPDM_OFF_PINBASE  8'h40

// pin-form field positions
`define IOPDM_PF_OUT       0
`define IOPDM_PF_DM_LO     1
`define IOPDM_PF_DM_HI     3
`define IOPDM_PF_SLEW      4
`define IOPDM_PF_BYP       5
`define IOPDM_PF_RISE      6
`define IOPDM_PF_FALL      7

// reset values
`define IOPDM_RST_BYTE     8'h00
`define IOPDM_RST_AUX      32'h0000_0000

// series resistance of resistive modes, ohms (analog, reported only)
`define IOPDM_RES_OHMS     5000

`endif

// file: hdl/iopdm_pkg.sv
// package with the types of the pin drive mode port
package iopdm_pkg;

  // eight drive modes, codes are the mode number
  typedef enum logic [2:0] {
    IOPDM_HIZ_ANALOG  = 3'h0,
    IOPDM_HIZ_DIGITAL = 3'h1,
    IOPDM_RES_PULLUP  = 3'h2,
    IOPDM_RES_PULLDN  = 3'h3,
    IOPDM_OD_LOW      = 3'h4,
    IOPDM_OD_HIGH     = 3'h5,
    IOPDM_STRONG      = 3'h6,
    IOPDM_RES_BOTH    = 3'h7
  } iopdm_mode_type;

  // per pin drive controls sent to the pad
  typedef struct packed {
    logic oe_strong;  // strong drive enabled
    logic oe_res;     // 5K resistive drive enabled
    logic level;      // driven level
    logic slow;       // slow slew selected
    logic in_en;      // digital input buffer on
  } iopdm_pad_type;

  // classic wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } iopdm_wbreq_type;

endpackage : iopdm_pkg

// file: hdl/iopdm_port.sv
// eight pin digital port: drive modes, bypass, slew, edge interrupts
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`include "iopdm_params.svh"

module iopdm_port #(
  parameter int NPIN = 8,   // pins per port
  parameter int NAUX = 16   // auxiliary output enable lines
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_resetn,
  input  wire iopdm_pkg::iopdm_wbreq_type i_wb,
  output logic [31:0]                   o_wb_dat,
  output logic                          o_wb_ack,
  input  wire logic [NPIN-1:0]          i_pin,
  input  wire logic [NPIN-1:0]          i_bypass_dat,
  input  wire logic [NAUX-1:0]          i_aux_oe,
  output iopdm_pkg::iopdm_pad_type [NPIN-1:0] o_pad,
  output logic [NPIN-1:0]               o_sys_in,
  output logic                          o_irq
);
  import iopdm_pkg::*;

  // elaboration checks: storage is byte wide, aux index is 4 bits
  if (NPIN != 8) begin : g_bad_npin
    $error("port logic serves exactly eight pins");
  end
  if (NAUX < 1 || NAUX > 16) begin : g_bad_naux
    $error("aux bus is 1 to 16 lines");
  end

  //////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  out_q;       // output data
  logic [7:0]  dm0_q;       // drive mode bit zero per pin
  logic [7:0]  dm1_q;       // drive mode bit one per pin
  logic [7:0]  dm2_q;       // drive mode bit two per pin
  logic [7:0]  slew_q;      // slow slew per pin
  logic [7:0]  byp_q;       // bypass select per pin
  logic [7:0]  rise_q;      // rising edge interrupt enable
  logic [7:0]  fall_q;      // falling edge interrupt enable
  logic [7:0]  stat_q;      // sticky interrupt status
  logic [7:0]  mask_q;      // interrupt mask
  logic [7:0]  auxen_q;     // pin follows an aux enable line
  logic [31:0] auxsel_q;    // 4-bit aux line index per pin
  logic [7:0]  pin_q;       // sampled pin levels
  logic [7:0]  pin_prev_q;  // previous sample for edges
  logic [7:0]  en_q;        // buffer enable of the pin_q sample
  logic [7:0]  en_prev_q;   // buffer enable of the pin_prev_q sample
  logic        ack_q;       // bus acknowledge

  //////////////////////////////////////////////////////////////////////
  // bus decode
  logic       wr_stb;       // write taken this cycle
  logic       rd_stb;       // read taken this cycle
  logic [7:0] wbyte;        // low write byte, lane zero
  logic       pin_hit;      // address in pin-form window
  logic [2:0] pin_idx;      // pin-form pin number
  assign wr_stb = i_wb.cyc & i_wb.stb & i_wb.we & ~ack_q;
  assign rd_stb = i_wb.cyc & i_wb.stb & ~i_wb.we & ~ack_q;
  assign wbyte  = i_wb.sel[0] ? i_wb.dat[7:0] : 8'h00;
  // pin form sits in 40..5C, word aligned
  assign pin_hit = (i_wb.adr[7:5] == 3'(`IOPDM_OFF_PINBASE >> 5))
                   && (i_wb.adr[1:0] == 2'h0);
  assign pin_idx = i_wb.adr[4:2];

  // write of one port-form byte register with lane zero enable
  function automatic logic [7:0] port_wr(input logic [7:0] cur,
                                         input logic [7:0] off);
    port_wr = (wr_stb && i_wb.sel[0] && i_wb.adr == off) ?
              wbyte : cur;
  endfunction

  // pin-form write of one bit of a port register
  function automatic logic [7:0] pin_wr(input logic [7:0] cur,
                                        input int         pos);
    logic [7:0] v;
    v = cur;
    if (wr_stb && pin_hit && i_wb.sel[0])
      v[pin_idx] = i_wb.dat[pos];
    pin_wr = v;
  endfunction

  // single-cycle ack, dropped the cycle after
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= i_wb.cyc & i_wb.stb & ~ack_q;
    end
  end

  // configuration: port view and pin view share storage [R11]
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_q  <= `IOPDM_RST_BYTE;
      dm0_q  <= `IOPDM_RST_BYTE;  // mode 000 after reset [R3]
      dm1_q  <= `IOPDM_RST_BYTE;
      dm2_q  <= `IOPDM_RST_BYTE;
      slew_q <= `IOPDM_RST_BYTE;
      byp_q  <= `IOPDM_RST_BYTE;
      rise_q <= `IOPDM_RST_BYTE;
      fall_q <= `IOPDM_RST_BYTE;
      mask_q <= `IOPDM_RST_BYTE;
      auxen_q <= `IOPDM_RST_BYTE;
    end else begin
      // port form first, pin form decodes a disjoint range [R11]
      out_q  <= pin_wr(port_wr(out_q, `IOPDM_OFF_OUT), `IOPDM_PF_OUT);
      dm0_q  <= pin_wr(port_wr(dm0_q, `IOPDM_OFF_DMB0),
                       `IOPDM_PF_DM_LO);             // [R1]
      dm1_q  <= pin_wr(port_wr(dm1_q, `IOPDM_OFF_DMB1),
                       `IOPDM_PF_DM_LO + 1);
      dm2_q  <= pin_wr(port_wr(dm2_q, `IOPDM_OFF_DMB2),
                       `IOPDM_PF_DM_HI);
      slew_q <= pin_wr(port_wr(slew_q, `IOPDM_OFF_SLEW),
                       `IOPDM_PF_SLEW);              // [R12]
      byp_q  <= pin_wr(port_wr(byp_q, `IOPDM_OFF_BYPASS),
                       `IOPDM_PF_BYP);
      rise_q <= pin_wr(port_wr(rise_q, `IOPDM_OFF_IRQRISE),
                       `IOPDM_PF_RISE);              // [R7]
      fall_q <= pin_wr(port_wr(fall_q, `IOPDM_OFF_IRQFALL),
                       `IOPDM_PF_FALL);
      mask_q <= port_wr(mask_q, `IOPDM_OFF_IRQMASK);
      auxen_q <= port_wr(auxen_q, `IOPDM_OFF_AUXEN);
    end
  end

  // aux line selection, 4 bits per pin
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      auxsel_q <= `IOPDM_RST_AUX;
    end else if (wr_stb && i_wb.adr == `IOPDM_OFF_AUXSEL) begin
      for (int b = 0; b < 4; b++) begin
        if (i_wb.sel[b]) auxsel_q[8*b +: 8] <= i_wb.dat[8*b +: 8];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // input path and edge interrupts
  logic [7:0] in_en;        // digital input buffer enable per pin
  logic [7:0] rise_ev;      // qualified rising edge
  logic [7:0] fall_ev;      // qualified falling edge
  logic [7:0] edge_ev;      // any configured edge [R13]
  logic [7:0] clr_bits;     // write-one-to-clear
  // mode 000 shuts the input buffer, so it reads zero [R3] [R4]
  assign in_en   = dm0_q | dm1_q | dm2_q;
  // edges count only once the buffer was on for both samples, so
  // switching a high pin out of mode 000 does not fake a rise
  assign rise_ev = en_q & en_prev_q & pin_q & ~pin_prev_q & rise_q;
  assign fall_ev = en_q & en_prev_q & ~pin_q & pin_prev_q & fall_q;
  // edges only; a steady level never fires [R8]
  assign edge_ev = rise_ev | fall_ev;
  assign clr_bits = (wr_stb && i_wb.sel[0]
                     && i_wb.adr == `IOPDM_OFF_IRQSTAT) ? wbyte : 8'h00;

  // pin sampling, gated by the input buffer
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_q      <= 8'h00;
      pin_prev_q <= 8'h00;
    end else begin
      pin_q      <= i_pin & in_en;
      pin_prev_q <= pin_q;
    end
  end

  // buffer enable delayed alongside the two pin samples
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      en_q      <= 8'h00;  // all pins start in mode 000 [R3]
      en_prev_q <= 8'h00;
    end else begin
      en_q      <= in_en;
      en_prev_q <= en_q;
    end
  end

  // sticky status, set wins over clear [R13]
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stat_q <= 8'h00;
    end else begin
      stat_q <= (stat_q & ~clr_bits) | edge_ev;
    end
  end

  // single port interrupt line, own to this port [R9]
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(((stat_q & ~clr_bits) | edge_ev) & mask_q);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // output path: pad drive decode per pin
  logic [7:0]    dval;      // data selected by bypass [R2]
  logic [7:0]    aux_on;    // aux enable state per pin [R14]
  iopdm_pad_type pad_d [8]; // next pad controls

  always_comb begin
    for (int p = 0; p < 8; p++) begin
      dval[p]   = byp_q[p] ? i_bypass_dat[p] : out_q[p];   // [R2]
      aux_on[p] = ~auxen_q[p] | i_aux_oe[auxsel_q[4*p +: 4] % NAUX];
      pad_d[p]  = '0;
      pad_d[p].level = dval[p];
      pad_d[p].in_en = in_en[p];
      pad_d[p].slow  = slew_q[p];                           // [R12]
      unique case (iopdm_mode_type'({dm2_q[p], dm1_q[p], dm0_q[p]}))
        IOPDM_HIZ_ANALOG, IOPDM_HIZ_DIGITAL: ;           // [R3] [R4]
        IOPDM_RES_PULLUP: begin                             // [R5]
          pad_d[p].oe_res    = dval[p];
          pad_d[p].oe_strong = ~dval[p];
        end
        IOPDM_RES_PULLDN: begin                             // [R5]
          pad_d[p].oe_res    = ~dval[p];
          pad_d[p].oe_strong = dval[p];
        end
        IOPDM_OD_LOW:  pad_d[p].oe_strong = ~dval[p];       // [R6]
        IOPDM_OD_HIGH: pad_d[p].oe_strong = dval[p];        // [R6]
        IOPDM_STRONG:  pad_d[p].oe_strong = 1'b1;           // [R6]
        IOPDM_RES_BOTH: pad_d[p].oe_res   = 1'b1;           // [R5]
      endcase
      // slew only meaningful on strong or open drain drive
      if (pad_d[p].oe_res) pad_d[p].slow = 1'b0;
      // aux line low holds pin high-z input [R14]
      if (!aux_on[p]) begin
        pad_d[p].oe_strong = 1'b0;
        pad_d[p].oe_res    = 1'b0;
        pad_d[p].in_en     = 1'b1;
      end
    end
  end

  // registered pad controls and system input
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pad    <= '0;
      o_sys_in <= 8'h00;
    end else begin
      for (int p = 0; p < 8; p++) o_pad[p] <= pad_d[p];
      o_sys_in <= pin_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read mux, pin levels separate from output data [R10]
  logic [31:0] rd_d;        // read data next value
  always_comb begin
    rd_d = 32'h0000_0000;
    if (pin_hit) begin
      rd_d[7:0] = {fall_q[pin_idx], rise_q[pin_idx], byp_q[pin_idx],
                   slew_q[pin_idx], dm2_q[pin_idx], dm1_q[pin_idx],
                   dm0_q[pin_idx], out_q[pin_idx]};
    end else begin
      unique case (i_wb.adr)
        `IOPDM_OFF_OUT:     rd_d[7:0] = out_q;
        `IOPDM_OFF_PINLVL:  rd_d[7:0] = pin_q;               // [R10]
        `IOPDM_OFF_DMB0:    rd_d[7:0] = dm0_q;
        `IOPDM_OFF_DMB1:    rd_d[7:0] = dm1_q;
        `IOPDM_OFF_DMB2:    rd_d[7:0] = dm2_q;
        `IOPDM_OFF_SLEW:    rd_d[7:0] = slew_q;
        `IOPDM_OFF_BYPASS:  rd_d[7:0] = byp_q;
        `IOPDM_OFF_IRQRISE: rd_d[7:0] = rise_q;
        `IOPDM_OFF_IRQFALL: rd_d[7:0] = fall_q;
        `IOPDM_OFF_IRQSTAT: rd_d[7:0] = stat_q;
        `IOPDM_OFF_IRQMASK: rd_d[7:0] = mask_q;
        `IOPDM_OFF_AUXEN:   rd_d[7:0] = auxen_q;
        `IOPDM_OFF_AUXSEL:  rd_d      = auxsel_q;
        default:            rd_d      = 32'h0000_0000;  // unmapped
      endcase
    end
  end

  // read data register, zero outside reads
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_dat <= rd_stb ? rd_d : 32'h0000_0000;
    end
  end
  assign o_wb_ack = ack_q;

  //////////////////////////////////////////////////////////////////////
  // assertions
  a_mode_zero_off: assert property (@(posedge i_clk) disable iff (!i_resetn)
    {dm2_q[0], dm1_q[0], dm0_q[0]} == 3'h0 && auxen_q[0] == 1'b0
    |=> !o_pad[0].oe_strong && !o_pad[0].oe_res && !o_pad[0].in_en) // [R3]
    else $error("mode zero pin not fully off");
  a_strong_drive: assert property (@(posedge i_clk) disable iff (!i_resetn)
    {dm2_q[1], dm1_q[1], dm0_q[1]} == 3'h6 && !byp_q[1] && !auxen_q[1]
    |=> o_pad[1].oe_strong && o_pad[1].level == $past(out_q[1])) // [R6]
    else $error("strong mode not driving data");
  a_od_low_float: assert property (@(posedge i_clk) disable iff (!i_resetn)
    {dm2_q[2], dm1_q[2], dm0_q[2]} == 3'h4 && out_q[2] && !byp_q[2]
    && !auxen_q[2] |=> !o_pad[2].oe_strong && !o_pad[2].oe_res) // [R6]
    else $error("open drain low drove a one");
  a_res_pullup: assert property (@(posedge i_clk) disable iff (!i_resetn)
    {dm2_q[3], dm1_q[3], dm0_q[3]} == 3'h2 && out_q[3] && !byp_q[3]
    && !auxen_q[3] |=> o_pad[3].oe_res && !o_pad[3].oe_strong) // [R5]
    else $error("pull-up mode not resistive high");
  a_bypass_data: assert property (@(posedge i_clk) disable iff (!i_resetn)
    byp_q[1] |=> o_pad[1].level == $past(i_bypass_dat[1])) // [R2]
    else $error("bypass data not routed");
  a_edge_sets: assert property (@(posedge i_clk) disable iff (!i_resetn)
    edge_ev != 8'h00
    |=> (stat_q & $past(edge_ev)) == $past(edge_ev)) // [R13]
    else $error("edge did not set status");
  a_irq_follows: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (stat_q & mask_q) != 8'h00 && clr_bits == 8'h00 |=> o_irq) // [R9]
    else $error("interrupt not raised");
  a_pin_read_keeps: assert property (@(posedge i_clk) disable iff (!i_resetn)
    rd_stb |=> out_q == $past(out_q)) // [R10]
    else $error("read changed output data");
  a_level_no_irq: assert property (@(posedge i_clk) disable iff (!i_resetn)
    pin_q == pin_prev_q |-> edge_ev == 8'h00) // [R8]
    else $error("steady level raised event");
  a_ack_one: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  // drive decode checks pick one pin each; all pins share the logic
  a_res_both: assert property (@(posedge i_clk) disable iff (!i_resetn)
    {dm2_q[5], dm1_q[5], dm0_q[5]} == 3'h7 && !auxen_q[5]
    |=> o_pad[5].oe_res && !o_pad[5].oe_strong) // [R5]
    else $error("mode seven not resistive both ways");
  a_slew_res: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_pad[0].oe_res |-> !o_pad[0].slow) // [R12]
    else $error("slow slew on resistive drive");
  a_aux_hiz: assert property (@(posedge i_clk) disable iff (!i_resetn)
    auxen_q[1] && !i_aux_oe[auxsel_q[7:4] % NAUX] |=> !o_pad[1].oe_strong
    && !o_pad[1].oe_res && o_pad[1].in_en) // [R14]
    else $error("aux low did not release pin");
  a_irq_clears: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (stat_q & mask_q) == 8'h00 && edge_ev == 8'h00 |=> !o_irq) // [R9]
    else $error("interrupt high with nothing pending");

  // main scenarios
  c_rise_irq: cover property (@(posedge i_clk) disable iff (!i_resetn)
    rise_ev != 8'h00 ##1 o_irq);
  c_fall_irq: cover property (@(posedge i_clk) disable iff (!i_resetn)
    fall_ev != 8'h00);
  c_pin_form: cover property (@(posedge i_clk) disable iff (!i_resetn)
    wr_stb && pin_hit);
  c_aux_hiz: cover property (@(posedge i_clk) disable iff (!i_resetn)
    auxen_q != 8'h00 && i_aux_oe == '0);

endmodule // iopdm_port

// file: sim/iopdm_pins_model.sv
// board model: resolves each pad against an optional external driver
`timescale 1ns/1ns

module iopdm_pins_model (
  input  wire logic                           i_clk,
  input  wire iopdm_pkg::iopdm_pad_type [7:0] i_pad,
  input  wire logic [7:0]                     i_ext_en,
  input  wire logic [7:0]                     i_ext_val,
  output logic [7:0]                          o_pin
);
  import iopdm_pkg::*;

  logic [7:0] last_q = 8'h00;  // last resolved level of each pin

  ////////////////////////////////////////////////////////////////////////////
  // strong drive beats the board, the board beats 5K, a floating pin wanders
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      if (i_pad[p].oe_strong) begin  // strong drive
        o_pin[p] = i_pad[p].level;
      end else if (i_ext_en[p]) begin  // external source wins over 5K
        o_pin[p] = i_ext_val[p];
      end else if (i_pad[p].oe_res) begin  // resistive drive
        o_pin[p] = i_pad[p].level;
      end else begin  // inverse of last, so a float never looks stable
        o_pin[p] = ~last_q[p];
      end
    end
  end

  // remembers the level so a floating pin keeps changing
  always_ff @(posedge i_clk) begin
    last_q <= o_pin;
  end
endmodule // iopdm_pins_model

// file: sim/iopdm_port_tb.sv
// testbench for the pin drive mode port: register, pad and interrupt tests
`timescale 1ns/1ns
`include "iopdm_params.svh"

module iopdm_port_tb;
  import iopdm_pkg::*;

  logic                      i_clk = 1'b0;     // system clock
  logic                      i_resetn = 1'b0;  // async reset, low active
  iopdm_wbreq_type           wb_req = '0;      // bus request
  logic [31:0]               o_wb_dat;         // read data
  logic                      o_wb_ack;         // bus answer
  logic [7:0]                pin;              // resolved pin levels
  logic [7:0]                byp = 8'h00;      // bypass data
  logic [15:0]               aux = 16'h0000;   // auxiliary enables
  iopdm_pad_type [7:0]       o_pad;            // pad controls
  logic [7:0]                o_sys_in;         // levels to the system
  logic                      o_irq;            // port interrupt
  logic [7:0]                ext_en = 8'h00;   // board drives pin
  logic [7:0]                ext_val = 8'h00;  // board level
  int                        fails = 0;        // mismatches
  int                        compares = 0;     // comparisons
  logic [31:0]               rd;               // last read value

  always #10 i_clk = ~i_clk;  // 50 MHz

  iopdm_port dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_wb(wb_req),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_pin(pin),
    .i_bypass_dat(byp), .i_aux_oe(aux), .o_pad(o_pad),
    .o_sys_in(o_sys_in), .o_irq(o_irq));

  iopdm_pins_model board (.i_clk(i_clk), .i_pad(o_pad), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_pin(pin));

  ////////////////////////////////////////////////////////////////////////////
  // one comparison, counted; a mismatch is reported at once
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // classic single cycle; holds the request until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] dat);
    @(posedge i_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
    // no limit here: only the watchdog ends a hung wait
    do begin
      @(posedge i_clk);
    end while (o_wb_ack !== 1'b1);
    rd = o_wb_dat;
    wb_req <= '0;
  endtask

  // lets pad and interrupt pipelines settle
  task automatic wait_n(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // expected {strong, resistive} drive for a mode and data bit
  function automatic logic [1:0] exp_drv(input logic [2:0] m, input logic d);
    case (m)
      3'h2: return d ? 2'h1 : 2'h2;
      3'h3: return d ? 2'h2 : 2'h1;
      3'h4: return d ? 2'h0 : 2'h2;
      3'h5: return d ? 2'h2 : 2'h0;
      3'h6: return 2'h2;
      3'h7: return 2'h1;
      default: return 2'h0;  // both high impedance modes
    endcase
  endfunction

  // prints counts and verdict, ends the run
  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: whole run is a few hundred cycles, limit is 20000
  initial begin
    #400000;
    fails++;
    print_verdict();
  end

  // main sequence
  initial begin
    logic [1:0] e;
    wait_n(3);
    i_resetn <= 1'b1;
    for (int a = 0; a <= 8'h40; a += 4) begin  // reset values, unmapped 34 to 3C
      wb(1'b0, a[7:0], 32'h0);
      chk("reset", rd, 32'h0);
    end
    chk("pad0", 32'(o_pad[0]), 32'h0);
    for (int m = 0; m < 8; m++) begin  // every drive mode, both data values
      for (int d = 0; d < 2; d++) begin
        wb(1'b1, `IOPDM_OFF_DMB0, {24'h0, {8{m[0]}}});
        wb(1'b1, `IOPDM_OFF_DMB1, {24'h0, {8{m[1]}}});
        wb(1'b1, `IOPDM_OFF_DMB2, {24'h0, {8{m[2]}}});
        wb(1'b1, `IOPDM_OFF_OUT, {24'h0, {8{d[0]}}});
        wait_n(2);
        e = exp_drv(m[2:0], d[0]);
        chk("drv", {o_pad[7].oe_strong, o_pad[7].oe_res}, e);
        if (e != 2'h0) begin
          chk("lvl", o_pad[0].level, d);
        end
        if (m < 2) begin
          chk("in_en", o_pad[0].in_en, m);
        end
      end
    end
    // pin form: pin 1 mode 6 data 0, pin 0 left in mode 7
    wb(1'b1, `IOPDM_OFF_PINBASE + 8'h04, 32'h0C);
    wb(1'b0, `IOPDM_OFF_DMB0, 32'h0);
    chk("dmb0", rd, 32'hFD);
    wb(1'b0, `IOPDM_OFF_PINBASE + 8'h04, 32'h0);
    chk("pinform", rd, 32'h0C);
    wb(1'b1, `IOPDM_OFF_SLEW, 32'h03);
    wb(1'b1, `IOPDM_OFF_BYPASS, 32'h02);
    byp <= 8'h02;
    wait_n(2);
    chk("byp", o_pad[1].level, 1'b1);
    chk("slow6", o_pad[1].slow, 1'b1);
    chk("slow7", o_pad[0].slow, 1'b0);
    chk("oth", {o_pad[0].oe_strong, o_pad[0].oe_res}, 2'h1);
    // pin 1 follows auxiliary line 15
    wb(1'b1, `IOPDM_OFF_AUXSEL, 32'hF0);
    wb(1'b1, `IOPDM_OFF_AUXEN, 32'h02);
    wait_n(2);
    chk("aux0", {o_pad[1].oe_strong, o_pad[1].in_en}, 2'h1);
    aux <= 16'h8000;
    wait_n(3);
    chk("aux1", o_pad[1].oe_strong, 1'b1);
    // all pins digital input, board drives them
    wb(1'b1, `IOPDM_OFF_AUXEN, 32'h0);
    wb(1'b1, `IOPDM_OFF_DMB0, 32'hFF);
    wb(1'b1, `IOPDM_OFF_DMB1, 32'h0);
    wb(1'b1, `IOPDM_OFF_DMB2, 32'h0);
    wb(1'b1, `IOPDM_OFF_OUT, 32'h3C);
    ext_en <= 8'hFF;
    ext_val <= 8'hA5;
    wait_n(4);
    wb(1'b1, `IOPDM_OFF_PINLVL, 32'h00);
    wb(1'b0, `IOPDM_OFF_PINLVL, 32'h0);
    chk("lvl_rd", rd, 32'hA5);
    chk("sys_in", o_sys_in, 8'hA5);
    wb(1'b0, `IOPDM_OFF_OUT, 32'h0);
    chk("out_rd", rd, 32'h3C);
    // edges: pin 0 rise, pin 1 fall, pin 2 both; others none
    ext_val <= 8'h00;
    wb(1'b1, `IOPDM_OFF_IRQRISE, 32'h05);
    wb(1'b1, `IOPDM_OFF_IRQFALL, 32'h06);
    wb(1'b1, `IOPDM_OFF_IRQSTAT, 32'hFF);
    ext_val <= 8'hFF;
    wait_n(5);
    wb(1'b0, `IOPDM_OFF_IRQSTAT, 32'h0);
    chk("st_rise", rd, 32'h05);
    chk("irq_mask", o_irq, 1'b0);
    wb(1'b1, `IOPDM_OFF_IRQMASK, 32'h04);
    wait_n(2);
    chk("irq_on", o_irq, 1'b1);
    wb(1'b1, `IOPDM_OFF_IRQSTAT, 32'h04);
    wait_n(2);
    chk("irq_clr", o_irq, 1'b0);
    wb(1'b0, `IOPDM_OFF_IRQSTAT, 32'h0);
    chk("st_w1c", rd, 32'h01);
    ext_val <= 8'h00;
    wait_n(5);
    wb(1'b0, `IOPDM_OFF_IRQSTAT, 32'h0);
    chk("st_fall", rd, 32'h07);
    chk("irq_f", o_irq, 1'b1);
    // pin 0 back to mode 000 via pin form: no input, no events
    wb(1'b1, `IOPDM_OFF_PINBASE, 32'h40);
    wb(1'b1, `IOPDM_OFF_IRQSTAT, 32'hFF);
    ext_val <= 8'h01;
    wait_n(5);
    wb(1'b0, `IOPDM_OFF_IRQSTAT, 32'h0);
    chk("st_off", rd, 32'h00);
    chk("sys_off", o_sys_in[0], 1'b0);
    chk("irq_off", o_irq, 1'b0);
    print_verdict();
  end
endmodule // iopdm_port_tb
